// ==== shared/fsk_pkg.sv ====
package fsk_pkg;
  // register indexes are word offsets, so byte address is index times four
  localparam logic [15:0] FSK_IDX_OPTION = 16'h1821;
  localparam logic [15:0] FSK_IDX_CONFIG = 16'h1823;
  localparam logic [15:0] FSK_IDX_PROTECT = 16'h1824;
  localparam logic [15:0] FSK_IDX_KEY_LO = 16'h1828;
  localparam logic [15:0] FSK_IDX_KEY_HI = 16'h1829;
  localparam logic [15:0] FSK_IDX_KEY_GO = 16'h182a;
  localparam logic [15:0] FSK_IDX_STATUS = 16'h182b;
  localparam logic [15:0] FSK_IDX_ERASE = 16'h182c;
  // nonvolatile locations inside the flash array
  localparam logic [15:0] FSK_NV_FINE_TRIM = 16'hffae;
  localparam logic [15:0] FSK_NV_CLOCK_TRIM = 16'hffaf;
  localparam logic [15:0] FSK_NV_KEY_FIRST = 16'hffb0;
  localparam logic [15:0] FSK_NV_KEY_LAST = 16'hffb7;
  localparam logic [15:0] FSK_NV_PROTECT = 16'hffbd;
  localparam logic [15:0] FSK_NV_OPTION = 16'hffbf;
  // option byte fields
  localparam int FSK_KEY_ENABLE_POS = 7;
  localparam int FSK_REDIRECT_POS = 6;
  localparam logic [1:0] FSK_SEC_UNSECURED = 2'h2;
  // config byte
  localparam int FSK_KEY_ACCESS_POS = 5;
  // flash commands
  localparam logic [7:0] FSK_CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] FSK_CMD_MASS_ERASE = 8'h41;
  // reset values
  localparam logic [7:0] FSK_CONFIG_RESET = 8'h00;
  localparam logic [7:0] FSK_PROTECT_RESET = 8'hff;
  localparam logic [7:0] FSK_OPTION_RESET = 8'h00;
  localparam logic [31:0] FSK_UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [1:0] FSK_RESP_OKAY = 2'h0;
  localparam logic [1:0] FSK_RESP_SLVERR = 2'h2;
  localparam logic [3:0] FSK_LOAD_STEPS = 4'ha;
  typedef enum logic [1:0] {
    FSK_LOAD = 2'b00,
    FSK_RUN = 2'b01
  } fsk_phase_t;
endpackage : fsk_pkg

// ==== hw/fsk_security.sv ====
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
// Functional notes
// - reset copies protect and option bytes to working
// - key unlock only while key enable is one
// - key compare only from secure memory code
// - debug port can never submit the key
// - key enable zero disables key mechanism
// - key disabled: unsecure after mass erase plus blank
// - security field 1:0 alone means unsecured
// - key held at nv locations ffb0 to ffb7
// - secured: block debug and nonsecure ram access
module fsk_security
  import fsk_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write
  input wire logic [17:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [17:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // access source of the current bus master
  input wire logic src_secure_code_in,
  input wire logic src_debug_in,
  // nonvolatile array read port
  output logic [15:0] nv_addr_out,
  input wire logic [7:0] nv_data_in,
  // flash command engine results
  input wire logic cmd_done_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic cmd_blank_in,
  // ram access gate
  input wire logic ram_req_in,
  output logic ram_grant_out,
  // state
  output logic secured_out,
  output logic [7:0] protect_out,
  output logic redirect_disable_out,
  output logic load_done_out
);

  typedef struct packed {
    fsk_phase_t phase;
    logic [3:0] step;
    logic [7:0] protect;
    logic [7:0] option;
    logic [63:0] stored_key;
    logic [63:0] entry_key;
    logic [7:0] config_reg;
    logic unlocked;
    logic key_fail;
    logic erased;
    logic mass_erased;
    logic aw_held;
    logic [15:0] aw_idx;
    logic w_held;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsk_state_t;

  fsk_state_t st;
  fsk_state_t next_st;

  function automatic logic sec_open(input logic [7:0] opt);
    sec_open = (opt[1:0] == FSK_SEC_UNSECURED);
  endfunction : sec_open

  function automatic logic idx_known(input logic [15:0] idx);
    idx_known = (idx == FSK_IDX_OPTION) || (idx == FSK_IDX_CONFIG) ||
      (idx == FSK_IDX_PROTECT) || (idx == FSK_IDX_KEY_LO) || (idx == FSK_IDX_KEY_HI) ||
      (idx == FSK_IDX_KEY_GO) || (idx == FSK_IDX_STATUS) || (idx == FSK_IDX_ERASE);
  endfunction : idx_known

  function automatic logic [15:0] nv_addr_for(input logic [3:0] step);
    case (step)
      FSK_LOAD_STEPS - 4'h2: nv_addr_for = FSK_NV_PROTECT;
      FSK_LOAD_STEPS - 4'h1: nv_addr_for = FSK_NV_OPTION;
      default: nv_addr_for = FSK_NV_KEY_FIRST + {12'h0, step};
    endcase
  endfunction : nv_addr_for

  // key words are write only so software can never read the key back
  function automatic logic [31:0] read_word(input fsk_state_t s, input logic [15:0] idx,
      input logic sec);
    case (idx)
      FSK_IDX_OPTION: read_word = {24'h0, s.option[7:6], 4'h0, s.option[1:0]};
      FSK_IDX_CONFIG: read_word = {24'h0, s.config_reg};
      FSK_IDX_PROTECT: read_word = {24'h0, s.protect};
      FSK_IDX_STATUS: read_word = {28'h0, s.erased, s.key_fail, s.unlocked, sec};
      default: read_word = FSK_UNMAPPED_DATA;
    endcase
  endfunction : read_word

  // key words and the compare need an allowed source with key access set
  function automatic logic key_write_ok(input logic allowed, input logic [7:0] cfg);
    key_write_ok = allowed && cfg[FSK_KEY_ACCESS_POS];
  endfunction : key_write_ok

  // key words need all four lanes so a partial write cannot mix old and new bytes
  function automatic logic lane_full(input logic [3:0] strb);
    lane_full = &strb;
  endfunction : lane_full

  logic secured;
  logic sec_by_option;
  logic sec_by_key;
  logic sec_by_erase;
  logic key_enabled;
  logic src_trusted;
  logic key_allowed;
  logic key_match;
  logic [7:0] key_byte_match;
  logic run_phase;
  logic ram_open;
  logic do_write;
  logic [15:0] ar_idx;

  // security lifts by the option field, a key match, or erase plus blank check
  assign sec_by_option = sec_open(st.option);
  assign sec_by_key = st.unlocked;
  assign sec_by_erase = st.erased;
  assign secured = !(sec_by_option || sec_by_key || sec_by_erase);
  // key path needs key enable, secure code, and never the debug port
  assign key_enabled = st.option[FSK_KEY_ENABLE_POS];
  assign src_trusted = src_secure_code_in && !src_debug_in;
  assign key_allowed = key_enabled && src_trusted;
  // ram gate only opens once loading is done
  assign run_phase = (st.phase == FSK_RUN);
  // write completes once address and data are held and no response waits
  assign do_write = st.aw_held && st.w_held && !st.bvalid;
  assign ar_idx = s_axi_araddr_in[17:2];

  // byte-wise compare, all eight must agree
  for (genvar i = 0; i < 8; i++) begin : g_key_cmp
    assign key_byte_match[i] = (st.entry_key[8*i +: 8] == st.stored_key[8*i +: 8]);
  end
  assign key_match = &key_byte_match;

  always_comb begin
    next_st = st;
    // nonvolatile load sequence, runs after every reset
    if (st.phase == FSK_LOAD) begin
      // steps 0 to 7 shift in key bytes; the byte from the first
      // location ends up in bits 7:0 after eight shifts
      case (st.step)
        FSK_LOAD_STEPS - 4'h1: begin
          next_st.option = nv_data_in;
          next_st.phase = FSK_RUN;
        end
        FSK_LOAD_STEPS - 4'h2: begin
          next_st.protect = nv_data_in;
          next_st.step = st.step + 4'h1;
        end
        default: begin
          next_st.stored_key = {nv_data_in, st.stored_key[63:8]};
          next_st.step = st.step + 4'h1;
        end
      endcase
    end
    // erase then blank check lifts security when the key is off
    if (cmd_done_in && st.phase == FSK_RUN) begin
      // a blank check only counts when a mass erase came first
      if (cmd_code_in == FSK_CMD_MASS_ERASE) begin
        next_st.erased = 1'b0;
        next_st.mass_erased = 1'b1;
      end else if (cmd_code_in == FSK_CMD_BLANK_CHECK) begin
        if (cmd_blank_in && st.mass_erased && !key_enabled) begin
          next_st.erased = 1'b1;
        end
        if (!cmd_blank_in) begin
          next_st.mass_erased = 1'b0;
        end
      end else begin
        // any other command may write the array again
        next_st.mass_erased = 1'b0;
      end
    end
    // write channel
    if (s_axi_awvalid_in && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = s_axi_awaddr_in[17:2];
    end
    if (s_axi_wvalid_in && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata_in;
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = idx_known(st.aw_idx) ? FSK_RESP_OKAY : FSK_RESP_SLVERR;
      case (st.aw_idx)
        FSK_IDX_CONFIG: begin
          if (s_axi_wstrb_in[0] && key_allowed) begin
            next_st.config_reg[FSK_KEY_ACCESS_POS] = st.wdata[FSK_KEY_ACCESS_POS];
          end
        end
        FSK_IDX_PROTECT: begin
          // protection may only be tightened, never loosened, until reset
          if (s_axi_wstrb_in[0] && !secured) begin
            next_st.protect = st.protect & st.wdata[7:0];
          end
        end
        FSK_IDX_KEY_LO: begin
          if (key_write_ok(key_allowed, st.config_reg) && lane_full(s_axi_wstrb_in)) begin
            next_st.entry_key[31:0] = st.wdata;
          end
        end
        FSK_IDX_KEY_HI: begin
          if (key_write_ok(key_allowed, st.config_reg) && lane_full(s_axi_wstrb_in)) begin
            next_st.entry_key[63:32] = st.wdata;
          end
        end
        FSK_IDX_KEY_GO: begin
          // every attempt spends key access, so each guess needs a fresh arm
          if (key_write_ok(key_allowed, st.config_reg)) begin
            if (key_match) begin
              next_st.unlocked = 1'b1;
              next_st.key_fail = 1'b0;
            end else begin
              next_st.key_fail = 1'b1;
            end
            next_st.config_reg[FSK_KEY_ACCESS_POS] = 1'b0;
          end
        end
        default: begin
          next_st.bresp = idx_known(st.aw_idx) ? FSK_RESP_OKAY : FSK_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    // read channel; key registers never read back
    if (s_axi_arvalid_in && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = idx_known(ar_idx) ? FSK_RESP_OKAY : FSK_RESP_SLVERR;
      // read data comes from the state before this edge
      next_st.rdata = read_word(st, ar_idx, secured);
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
  end

  // reset clears unlock and erase flags, so neither outlives a reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.phase <= FSK_LOAD;
      st.protect <= FSK_PROTECT_RESET;
      st.option <= FSK_OPTION_RESET;
      st.config_reg <= FSK_CONFIG_RESET;
      st.bresp <= FSK_RESP_OKAY;
      st.rresp <= FSK_RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  // nv address per load step: key bytes, then protect, then option
  assign nv_addr_out = nv_addr_for(st.step);

  // ram is blocked for debug and nonsecure code while secured
  assign ram_open = !secured || src_trusted;
  assign ram_grant_out = ram_req_in && ram_open && run_phase;

  // handshake outputs straight from state, no path from inputs
  assign s_axi_awready_out = !st.aw_held;
  assign s_axi_wready_out = !st.w_held;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_arready_out = !st.rvalid;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;
  assign secured_out = secured || (st.phase == FSK_LOAD);
  assign protect_out = st.protect;
  assign redirect_disable_out = st.option[FSK_REDIRECT_POS];
  assign load_done_out = (st.phase == FSK_RUN);

endmodule : fsk_security

// ==== tb/fsk_assertions.sv ====
`timescale 1ns/100ps
module fsk_assertions (
  // clock, reset, bus
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  // gate and state
  input wire logic src_secure_code_in,
  input wire logic src_debug_in,
  input wire logic ram_req_in,
  input wire logic ram_grant_out,
  input wire logic secured_out,
  input wire logic [7:0] protect_out,
  input wire logic load_done_out
);
  wire ok = !secured_out || (src_secure_code_in && !src_debug_in);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_secured: assert property ($fell(rst_in) |-> secured_out && protect_out == 8'hff)
    else $error("not secured after reset");
  a_load_bound: assert property ($fell(rst_in) |-> ##[5:14] load_done_out)
    else $error("load did not finish");
  a_load_secure: assert property (!load_done_out |-> secured_out)
    else $error("unsecured during load");
  a_grant_gate: assert property (ram_grant_out |-> ram_req_in && load_done_out && ok)
    else $error("ram grant while blocked");
  a_grant_open: assert property (ram_req_in && load_done_out && ok |-> ram_grant_out)
    else $error("ram grant missing");
  a_unlock_sticky: assert property (load_done_out && !secured_out |=> !secured_out)
    else $error("security came back");
  a_protect_hold: assert property (load_done_out && secured_out |=> $stable(protect_out))
    else $error("protect changed while secured");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_resp_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
endmodule : fsk_assertions
bind fsk_security fsk_assertions i_chk (.*);

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  import fsk_pkg::*;
  logic clk_in, rst_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic s_axi_rready_in, src_secure_code_in, src_debug_in, cmd_done_in, cmd_blank_in, ram_req_in;
  logic ram_grant_out, secured_out, redirect_disable_out, load_done_out;
  logic [17:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rrsp;
  logic [15:0] nv_addr_out;
  logic [7:0] nv_data_in, cmd_code_in, protect_out, nv_prot, nv_opt;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  localparam logic [31:0] KEY = 32'h5a5a_5a5a;
  fsk_security i_dut (.*);
  // unused nv locations answer the inverted low address byte so a wrong address shows
  always_comb begin
    nv_data_in = ~nv_addr_out[7:0];
    if (nv_addr_out >= 16'hffb0 && nv_addr_out <= 16'hffb7) nv_data_in = 8'h5a;
    if (nv_addr_out == 16'hffbd) nv_data_in = nv_prot;
    if (nv_addr_out == 16'hffbf) nv_data_in = nv_opt;
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [17:0] a, input logic [31:0] d);
    logic ta, tw, dn;
    dn = 1'b0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!dn) begin
      @(negedge clk_in);
      ta = s_axi_awvalid_in && s_axi_awready_out;
      tw = s_axi_wvalid_in && s_axi_wready_out;
      dn = s_axi_bvalid_out;
      @(posedge clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
    end
    s_axi_bready_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task rd(input logic [17:0] a);
    logic ta, dn;
    dn = 1'b0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    while (!dn) begin
      @(negedge clk_in);
      ta = s_axi_arvalid_in && s_axi_arready_out;
      dn = s_axi_rvalid_out;
      rdat = s_axi_rdata_out;
      rrsp = s_axi_rresp_out;
      @(posedge clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
    end
    s_axi_rready_in <= 1'b0;
    @(posedge clk_in);
  endtask : rd
  task look(input string nm, input logic [31:0] exp, input logic [31:0] got);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(nm, exp, secured_out);
    chk("ram grant", got, ram_grant_out);
    @(posedge clk_in);
  endtask : look
  task load(input logic [7:0] p, input logic [7:0] o);
    nv_prot <= p;
    nv_opt <= o;
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (14) @(posedge clk_in);
    @(negedge clk_in);
    chk("load done", 1, load_done_out);
    chk("protect", p, protect_out);
    chk("redirect", o[6], redirect_disable_out);
    @(posedge clk_in);
  endtask : load
  task key_try(input logic sc, input logic db, input logic [31:0] hi, input logic ex);
    src_secure_code_in <= sc;
    src_debug_in <= db;
    wr(18'h608c, 32'h20);
    wr(18'h60a0, KEY);
    wr(18'h60a4, hi);
    wr(18'h60a8, 32'h0);
    look("secured", ex, !ex || (sc && !db));
  endtask : key_try
  task t_regs;
    load(8'hc3, 8'h80);
    rd(18'h6084);
    chk("option", 32'h80, rdat);
    rd(18'h0000);
    chk("unmapped resp", FSK_RESP_SLVERR, rrsp);
    chk("unmapped data", FSK_UNMAPPED_DATA, rdat);
  endtask : t_regs
  task t_keys;
    ram_req_in <= 1'b1;
    key_try(1'b1, 1'b1, KEY, 1'b1);
    key_try(1'b0, 1'b0, KEY, 1'b1);
    key_try(1'b1, 1'b0, KEY ^ 32'h100, 1'b1);
    key_try(1'b1, 1'b0, KEY, 1'b0);
    rd(18'h60ac);
    chk("status", 32'h2, rdat);
    wr(18'h6090, 32'h0f);
    rd(18'h6090);
    chk("protect tightened", 32'h03, rdat);
  endtask : t_keys
  task cmd(input logic [7:0] c, input logic ex);
    cmd_done_in <= 1'b1;
    cmd_code_in <= c;
    cmd_blank_in <= 1'b1;
    @(posedge clk_in);
    cmd_done_in <= 1'b0;
    look("secured after cmd", ex, !ex);
  endtask : cmd
  task t_erase;
    load(8'hff, 8'h00);
    key_try(1'b1, 1'b0, KEY, 1'b1);
    src_secure_code_in <= 1'b0;
    cmd(FSK_CMD_MASS_ERASE, 1'b1);
    cmd(FSK_CMD_BLANK_CHECK, 1'b0);
  endtask : t_erase
  task t_sec;
    load(8'hff, 8'h02);
    look("sec field 1:0", 0, 1);
    load(8'hff, 8'h03);
    look("sec field 1:1", 1, 0);
  endtask : t_sec
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, src_secure_code_in, src_debug_in, cmd_done_in} = 4'h0;
    {cmd_blank_in, ram_req_in, s_axi_awaddr_in, s_axi_araddr_in} = 38'h0;
    {s_axi_wdata_in, cmd_code_in, nv_prot, nv_opt} = 56'h0;
    s_axi_wstrb_in = 4'hf;
    rst_in = 1'b1;
    t_regs();
    t_keys();
    t_erase();
    t_sec();
    conclude();
  end
endmodule : tb
